// *** pkg/nfc_params.svh ***
// Constants for the NAND host sequencer: commands, register offsets, fields, timing
`ifndef NFC_PARAMS_SVH
`define NFC_PARAMS_SVH
// How it works
// [R1] Copy restarts from first step whenever destination block changes or increments; the host sets err_ff on a cache copy or on a poll timeout.
// [R2] Device loads source page to cache, then takes destination and optional data.
// [R3] Next source page may be read while previous destination still programs.
// [R4] Cache-continue command programs buffer and loads next source page.
// [R5] Copy ends with copy-destination command then final program command.
// [R6] Modified data is optional; only changed bytes are written after column address.
// [R7] Write-protect stays high for the whole page copy; during copy start wp_n follows the WP control bit only.
// [R8] Busy after final command spans both page program times, minus last-page cycles.
// [R9] Two-plane copy restarts whenever either block address changes.
// [R10] Erase starts only after setup command then confirm command.
// [R11] Multi erase: two setup-plus-address groups, one confirm, district status read.
// [R12] Even blocks are district 0, odd blocks district 1.
// [R13] At most one block per district, either order, no address relation.
// [R14] Multi erase ends with confirm; abandon only with reset command.
// [R15] Identification returns five bytes in fixed order.
// [R16] Third id byte: chip count bits 1:0, cell levels bits 3:2.
// [R17] Fourth id byte: page size 1:0, block size 5:4, bus width bit 6.
// [R18] Fifth id byte: plane count bits 3:2.
// [R19] Status-read command returns ready, pass/fail and protect state.
// [R20] Status read is allowed during a page read.
// [R21] District status: bit0 OR of districts, bits1-4 districts, 5 buffer, 6 cache, 7 unprotected.
// [R22] Plain status: bit0 current, bit1 previous, 2-4 zero, 5/6 ready bits.
// [R23] While busy only status reads and reset may be issued.
// [R24] Identification bytes come on consecutive read strobes from the first.
`define NFC_CMD_READ1 8'h00
`define NFC_CMD_READ2 8'h30
`define NFC_CMD_COPY_RD 8'h3A
`define NFC_CMD_COPY_DST 8'h8C
`define NFC_CMD_PROG 8'h10
`define NFC_CMD_CACHE 8'h15
`define NFC_CMD_ERASE1 8'h60
`define NFC_CMD_ERASE2 8'hD0
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_DSTATUS 8'h71
`define NFC_CMD_ID 8'h90
`define NFC_CMD_RESET 8'hFF
`define NFC_REG_CTRL 12'h000
`define NFC_REG_ADDR 12'h004
`define NFC_REG_ADDR2 12'h008
`define NFC_REG_WDATA 12'h00C
`define NFC_REG_STAT 12'h010
`define NFC_REG_RDATA 12'h014
`define NFC_REG_ID_LO 12'h018
`define NFC_REG_ID_HI 12'h01C
`define NFC_CTRL_OP_LSB 0
`define NFC_CTRL_GO 8
`define NFC_CTRL_WP 9
`define NFC_ST_RDY_BIT 5
`define NFC_ST_CACHE_BIT 6
`define NFC_ST_WP_BIT 7
`define NFC_ID_BYTES 5
`define NFC_STROBE_NS 25
`define NFC_POLL_MAX 16'hFFFF
`endif

// *** pkg/nfc_pkg.sv ***
// Types for the NAND host sequencer
package nfc_pkg;
	typedef enum logic [3:0] {
		NFC_OP_STATUS, NFC_OP_DSTATUS, NFC_OP_ID, NFC_OP_ERASE, NFC_OP_MERASE,
		NFC_OP_COPY_START, NFC_OP_COPY_CACHE, NFC_OP_COPY_LAST, NFC_OP_RESET, NFC_OP_RDBYTE, NFC_OP_WRBYTE
	} nfc_op_t;
	typedef enum logic [1:0] {NFC_CY_CMD, NFC_CY_ADDR, NFC_CY_WR, NFC_CY_RD} nfc_cy_t;
endpackage

// *** hdl/nfc_cycle.sv ***
// One bus cycle on the NAND pins: command, address, write or read
`timescale 1ns/1ps
`include "nfc_params.svh"
module nfc_cycle import nfc_pkg::*; #(
	parameter int CLK_NS = 5
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request
	input wire logic start,
	input wire nfc_cy_t kind,
	input wire logic [7:0] wbyte,
	output logic done,
	output logic [7:0] rbyte,
	// Pins
	output logic cle,
	output logic ale,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic [7:0] bus_out,
	output logic bus_oe_n,
	input wire logic [7:0] bus_in
);
	localparam int PH = (`NFC_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] PH_C = 4'(PH < 1 ? 1 : PH);
	logic [3:0] cnt_ff;
	logic [1:0] ph_ff;
	wire is_rd = (kind == NFC_CY_RD);
	wire cnt_end = (cnt_ff == 4'h0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 4'h0;
			ph_ff <= 2'h0;
			done <= 1'b0;
			rbyte <= 8'h00;
			cle <= 1'b0;
			ale <= 1'b0;
			write_strobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			bus_out <= 8'h00;
			bus_oe_n <= 1'b1;
		end else begin
			done <= 1'b0;
			if (ph_ff == 2'h0 && start) begin
				// Strobe low phase
				ph_ff <= 2'h1;
				// Count to zero inclusive, so load one less for PH_C clocks per phase
				cnt_ff <= PH_C - 4'h1;
				cle <= (kind == NFC_CY_CMD);
				ale <= (kind == NFC_CY_ADDR);
				bus_out <= wbyte;
				bus_oe_n <= is_rd;
				write_strobe_n <= is_rd;
				read_strobe_n <= !is_rd;
			end else if (ph_ff == 2'h1) begin
				cnt_ff <= cnt_ff - 4'h1;
				if (cnt_end) begin
					// Data is latched at this rising edge: by the device on a write, into rbyte on a read
					ph_ff <= 2'h2;
					cnt_ff <= PH_C - 4'h1;
					if (!read_strobe_n)
						rbyte <= bus_in;
					write_strobe_n <= 1'b1;
					read_strobe_n <= 1'b1;
				end
			end else if (ph_ff == 2'h2) begin
				cnt_ff <= cnt_ff - 4'h1;
				if (cnt_end) begin
					ph_ff <= 2'h0;
					cle <= 1'b0;
					ale <= 1'b0;
					bus_oe_n <= 1'b1;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// *** hdl/nfc_host.sv ***
// APB-controlled host sequencer for copy, erase, id and status on a NAND part
`timescale 1ns/1ps
`include "nfc_params.svh"
module nfc_host import nfc_pkg::*; #(
	parameter int CLK_NS = 5,
	parameter int NADDR_ROW = 3
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// NAND pins
	output logic cle,
	output logic ale,
	output logic ce_n,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic wp_n,
	output logic [7:0] bus_out,
	output logic bus_oe_n,
	input wire logic [7:0] bus_in,
	input wire logic ready_busy_n
);
	typedef enum logic [2:0] {S_IDLE, S_SEQ, S_CYC, S_WAIT, S_POLL, S_DONE} nfc_st_t;
	nfc_st_t st_ff, nxt_st;
	logic [3:0] op_ff;
	logic wp_ctl_ff;
	logic [31:0] addr_ff, addr2_ff;
	logic [7:0] wdata_ff, rdata_ff, status_ff;
	logic [39:0] id_ff;
	logic busy_ff, err_ff;
	logic [4:0] step_ff;
	logic [15:0] poll_ff;
	logic [10:0] last_blk_ff;
	logic chain_ff;
	logic dst_ff;
	logic pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	// Sequencer step output
	logic cyc_start_ff;
	nfc_cy_t cyc_kind_ff;
	logic [7:0] cyc_byte_ff;
	logic cyc_done;
	logic [7:0] cyc_rbyte;
	logic cle_i, ale_i, wsn_i, rsn_i, oe_i;
	logic [7:0] bo_i;
	nfc_cycle #(.CLK_NS(CLK_NS)) u_cyc (
		.pclk(pclk), .presetn(presetn), .start(cyc_start_ff), .kind(cyc_kind_ff),
		.wbyte(cyc_byte_ff), .done(cyc_done), .rbyte(cyc_rbyte), .cle(cle_i), .ale(ale_i),
		.write_strobe_n(wsn_i), .read_strobe_n(rsn_i), .bus_out(bo_i), .bus_oe_n(oe_i), .bus_in(bus_in)
	);
	assign cle = cle_i;
	assign ale = ale_i;
	assign write_strobe_n = wsn_i;
	assign read_strobe_n = rsn_i;
	assign bus_out = bo_i;
	assign bus_oe_n = oe_i;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	// APB decode
	wire apb_acc = psel && penable && !pready_ff;
	wire wr_ctrl = apb_acc && pwrite && paddr == `NFC_REG_CTRL;
	wire go = wr_ctrl && pwdata[`NFC_CTRL_GO] && !busy_ff;
	wire [3:0] new_op = pwdata[`NFC_CTRL_OP_LSB +: 4];
	wire blk_of_addr_chg = addr_ff[16:6] != last_blk_ff;
	wire mapped = paddr[11:5] == 7'h00;
	logic [31:0] rd_mux;
	always_comb begin
		unique case (paddr)
			`NFC_REG_CTRL: rd_mux = {22'h0, wp_ctl_ff, 5'h0, op_ff};
			`NFC_REG_ADDR: rd_mux = addr_ff;
			`NFC_REG_ADDR2: rd_mux = addr2_ff;
			`NFC_REG_WDATA: rd_mux = {24'h0, wdata_ff};
			`NFC_REG_STAT: rd_mux = {21'h0, chain_ff, err_ff, busy_ff, status_ff};
			`NFC_REG_RDATA: rd_mux = {24'h0, rdata_ff};
			`NFC_REG_ID_LO: rd_mux = id_ff[31:0];
			`NFC_REG_ID_HI: rd_mux = {24'h0, id_ff[39:32]};
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= psel && penable && !pready_ff;
			pslverr_ff <= apb_acc && (!mapped || (wr_ctrl && pwdata[`NFC_CTRL_GO] && busy_ff));
			prdata_ff <= apb_acc && !pwrite ? rd_mux : 32'h0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_ff <= 32'h0;
			addr2_ff <= 32'h0;
			wdata_ff <= 8'h00;
			wp_ctl_ff <= 1'b0;
		end else if (apb_acc && pwrite) begin
			if (paddr == `NFC_REG_ADDR) addr_ff <= pwdata;
			if (paddr == `NFC_REG_ADDR2) addr2_ff <= pwdata;
			if (paddr == `NFC_REG_WDATA) wdata_ff <= pwdata[7:0];
			if (wr_ctrl) wp_ctl_ff <= pwdata[`NFC_CTRL_WP];
		end
	end
	// Sequence table: each step is a cycle kind and byte; index past end closes the op
	logic seq_end, seq_wait;
	nfc_cy_t s_kind;
	logic [7:0] s_byte;
	logic [31:0] row;
	always_comb begin
		seq_end = 1'b0;
		seq_wait = 1'b0;
		s_kind = NFC_CY_CMD;
		s_byte = 8'h00;
		row = (op_ff == 4'(NFC_OP_MERASE) && step_ff >= 5'd4) ? addr2_ff : addr_ff; // R12
		unique case (nfc_op_t'(op_ff))
			NFC_OP_STATUS, NFC_OP_DSTATUS: begin // R19 R20 R21 R22
				if (step_ff == 5'd0) s_byte = (op_ff == 4'(NFC_OP_STATUS)) ? `NFC_CMD_STATUS : `NFC_CMD_DSTATUS;
				else if (step_ff == 5'd1) s_kind = NFC_CY_RD;
				else seq_end = 1'b1;
			end
			NFC_OP_ID: begin // R15 R24
				if (step_ff == 5'd0) s_byte = `NFC_CMD_ID;
				else if (step_ff == 5'd1) s_kind = NFC_CY_ADDR;
				else if (step_ff < 5'd2 + 5'(`NFC_ID_BYTES)) s_kind = NFC_CY_RD;
				else seq_end = 1'b1;
			end
			NFC_OP_ERASE, NFC_OP_MERASE: begin // R10 R11 R13 R14
				if (step_ff == 5'd0 || step_ff == 5'd4) s_byte = `NFC_CMD_ERASE1;
				else if (step_ff < 5'd4 || step_ff < 5'd8) begin
					s_kind = NFC_CY_ADDR;
					s_byte = row[8*((step_ff & 5'd3) - 5'd1) +: 8];
				end
				if (op_ff == 4'(NFC_OP_ERASE) && step_ff == 5'd4) begin
					s_kind = NFC_CY_CMD;
					s_byte = `NFC_CMD_ERASE2;
					seq_wait = 1'b1;
				end
				if (step_ff == 5'd8) begin
					s_kind = NFC_CY_CMD;
					s_byte = `NFC_CMD_ERASE2;
					seq_wait = 1'b1;
				end
				if (step_ff > 5'd8 || (op_ff == 4'(NFC_OP_ERASE) && step_ff > 5'd4)) seq_end = 1'b1;
			end
			NFC_OP_COPY_START: begin // R2
				if (step_ff == 5'd0) s_byte = `NFC_CMD_READ1;
				else if (step_ff < 5'd6) begin
					s_kind = NFC_CY_ADDR;
					s_byte = step_ff < 5'd3 ? 8'h00 : addr2_ff[8*(step_ff - 5'd3) +: 8];
				end else if (step_ff == 5'd6) begin
					s_byte = `NFC_CMD_COPY_RD;
					seq_wait = 1'b1;
				end else seq_end = 1'b1;
			end
			NFC_OP_COPY_CACHE, NFC_OP_COPY_LAST: begin // R3 R4 R5 R6
				if (step_ff == 5'd0) s_byte = `NFC_CMD_COPY_DST;
				else if (step_ff < 5'd6) begin
					s_kind = NFC_CY_ADDR;
					s_byte = step_ff < 5'd3 ? 8'h00 : addr_ff[8*(step_ff - 5'd3) +: 8];
				end else if (step_ff == 5'd6) begin
					s_byte = (op_ff == 4'(NFC_OP_COPY_LAST)) ? `NFC_CMD_PROG : `NFC_CMD_CACHE;
					seq_wait = 1'b1; // R8
				end else seq_end = 1'b1;
			end
			NFC_OP_RESET: begin
				if (step_ff == 5'd0) begin
					s_byte = `NFC_CMD_RESET;
					seq_wait = 1'b1;
				end else seq_end = 1'b1;
			end
			NFC_OP_RDBYTE: begin
				if (step_ff == 5'd0) s_kind = NFC_CY_RD;
				else seq_end = 1'b1;
			end
			NFC_OP_WRBYTE: begin // R6
				if (step_ff == 5'd0) begin
					s_kind = NFC_CY_WR;
					s_byte = wdata_ff;
				end else seq_end = 1'b1;
			end
			default: seq_end = 1'b1;
		endcase
	end
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			S_IDLE: if (go) nxt_st = S_SEQ;
			S_SEQ: nxt_st = seq_end ? S_DONE : S_CYC;
			S_CYC: if (cyc_done) nxt_st = seq_wait ? S_WAIT : S_SEQ;
			S_WAIT: if (!ready_busy_n) nxt_st = S_POLL;
			S_POLL: if (ready_busy_n || poll_ff == 16'h0) nxt_st = S_SEQ;
			S_DONE: nxt_st = S_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= S_IDLE;
			op_ff <= 4'h0;
			busy_ff <= 1'b0;
			err_ff <= 1'b0;
			step_ff <= 5'd0;
			poll_ff <= 16'h0;
			cyc_start_ff <= 1'b0;
			cyc_kind_ff <= NFC_CY_CMD;
			cyc_byte_ff <= 8'h00;
			status_ff <= 8'h00;
			rdata_ff <= 8'h00;
			id_ff <= 40'h0;
			last_blk_ff <= 11'h0;
			chain_ff <= 1'b0;
			dst_ff <= 1'b0;
			ce_n <= 1'b1;
			wp_n <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cyc_start_ff <= 1'b0;
			// Keep protection off from the end of copy start until copy last or reset ends
			wp_n <= wp_ctl_ff || chain_ff; // R7
			if (go) begin
				op_ff <= new_op;
				step_ff <= 5'd0;
				busy_ff <= 1'b1;
				ce_n <= 1'b0;
				// Flag only against a destination already written in this chain
				err_ff <= new_op == 4'(NFC_OP_COPY_CACHE) && chain_ff && dst_ff && blk_of_addr_chg; // R1 R9
			end
			if (st_ff == S_SEQ && !seq_end) begin
				cyc_start_ff <= 1'b1;
				cyc_kind_ff <= s_kind;
				cyc_byte_ff <= s_byte;
			end
			if (st_ff == S_CYC && cyc_done) begin
				step_ff <= step_ff + 5'd1;
				if (cyc_kind_ff == NFC_CY_RD) begin
					rdata_ff <= cyc_rbyte;
					if (op_ff == 4'(NFC_OP_ID)) id_ff <= {cyc_rbyte, id_ff[39:8]};
					if (op_ff <= 4'(NFC_OP_DSTATUS)) status_ff <= cyc_rbyte;
				end
				poll_ff <= `NFC_POLL_MAX;
			end
			if (st_ff == S_POLL) poll_ff <= poll_ff - 16'h1;
			if (st_ff == S_POLL && poll_ff == 16'h0 && !ready_busy_n) err_ff <= 1'b1;
			if (st_ff == S_DONE) begin
				busy_ff <= 1'b0;
				ce_n <= 1'b1;
				if (op_ff == 4'(NFC_OP_COPY_START)) chain_ff <= 1'b1;
				if (op_ff == 4'(NFC_OP_COPY_LAST) || op_ff == 4'(NFC_OP_RESET)) chain_ff <= 1'b0;
				if (op_ff == 4'(NFC_OP_COPY_START) || op_ff == 4'(NFC_OP_COPY_LAST) || op_ff == 4'(NFC_OP_RESET))
					dst_ff <= 1'b0;
				if (op_ff == 4'(NFC_OP_COPY_CACHE)) dst_ff <= 1'b1;
				if (op_ff == 4'(NFC_OP_COPY_CACHE) || op_ff == 4'(NFC_OP_COPY_LAST)) last_blk_ff <= addr_ff[16:6];
			end
			if (st_ff == S_IDLE && go && err_ff) busy_ff <= 1'b1;
		end
	end
endmodule

// *** sim/nfc_host_sva.sv ***
// Concurrent checks on the NAND host pins and its APB answers
`timescale 1ns/1ps
module nfc_host_sva (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// NAND pins
	input wire logic cle,
	input wire logic ce_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic wp_n,
	input wire logic [7:0] bus_out,
	input wire logic bus_oe_n,
	input wire logic ready_busy_n
);
	logic wstb_q_ff;
	logic [7:0] last_cmd_ff;
	// Seen one clock after the strobe rises, while the byte is still held
	wire cmd_edge = cle && write_strobe_n && !wstb_q_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wstb_q_ff <= 1'b1;
			last_cmd_ff <= 8'h00;
		end else begin
			wstb_q_ff <= write_strobe_n;
			if (cmd_edge) begin
				last_cmd_ff <= bus_out;
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_APB_WAIT: assert property ($rose(penable) && psel |=> pready) else $error("late apb answer");
	AST_HOLE: assert property (psel && pready && paddr >= 12'h020 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_WP_COPY: assert property (cmd_edge && bus_out inside {8'h3A, 8'h8C, 8'h15, 8'h10} |-> wp_n)
		else $error("protect low in copy");
	AST_ERASE_PAIR: assert property (cmd_edge && bus_out == 8'hD0 |-> last_cmd_ff == 8'h60)
		else $error("confirm without setup");
	AST_COPY_CLOSE: assert property (cmd_edge && bus_out inside {8'h10, 8'h15} |-> last_cmd_ff == 8'h8C)
		else $error("program without copy destination");
	AST_BUSY_CMD: assert property (cmd_edge && !$past(ready_busy_n) |-> bus_out inside {8'h70, 8'h71, 8'hFF})
		else $error("command while busy");
	AST_WR_PULSE: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
		else $error("write strobe width");
	AST_RD_RELEASE: assert property (!read_strobe_n |-> bus_oe_n && !ce_n)
		else $error("bus driven on read");
	AST_WR_DRIVE: assert property (!write_strobe_n |-> !bus_oe_n && !ce_n) else $error("bus idle on write");
endmodule

// *** sim/nfc_dev.sv ***
// Behavioural NAND part: command decode, addressing, id, status and busy
`timescale 1ns/1ps
module nfc_dev #(
	parameter logic [7:0] MFR_CODE = 8'h5A,
	parameter logic [7:0] DEV_CODE = 8'hC3,
	parameter int BUSY_NS = 1500
) (
	// Control pins
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic wp_n,
	// Data and busy
	input wire logic [7:0] bus_in,
	output logic [7:0] dev_q,
	output logic ready_busy_n,
	// Erase of an odd block fails
	input wire logic fail_odd
);
	logic [7:0] cmd = 8'h00;
	logic [23:0] row = 24'h0, row_a = 24'h0, src = 24'h0, last_dst = 24'h0;
	logic [2:0] rd_i = 3'd0;
	logic d0_f = 1'b0, d1_f = 1'b0;
	int n_blk = 0, prog_cnt = 0;
	// One chip, two-level cells; x8, 128 KB block, 2 KB page; two planes
	wire [39:0] id_w = {{4'h7, 2'b01, 2'b10}, {2'b00, 2'b01, 2'b01, 2'b01}, {4'h9, 2'b00, 2'b00}, DEV_CODE, MFR_CODE};
	initial dev_q = 8'h00;
	initial ready_busy_n = 1'b1;
	always @(posedge write_strobe_n) begin
		if (!ce_n && cle) begin
			cmd = bus_in;
			rd_i = 3'd0;
			if (bus_in == 8'h60) begin
				if (n_blk == 1) row_a = row;
				n_blk++;
			end
			if (bus_in == 8'hD0) begin
				d0_f = 1'b0;
				d1_f = fail_odd && (row[6] || (n_blk == 2 && row_a[6]));
				n_blk = 0;
			end
			if (bus_in == 8'h3A) src = row;
			if (bus_in == 8'h15) src = src + 24'd1;
			if (bus_in == 8'h15 || bus_in == 8'h10) begin
				last_dst = row;
				prog_cnt++;
			end
			if (bus_in == 8'hFF) begin
				{d0_f, d1_f} = 2'b00;
				n_blk = 0;
			end
			if (bus_in inside {8'h3A, 8'h15, 8'h10, 8'hD0, 8'hFF}) begin
				ready_busy_n = 1'b0;
				#((bus_in == 8'h10 ? 2 : 1) * BUSY_NS) ready_busy_n = 1'b1;
			end
		end else if (!ce_n && ale) begin
			row = {bus_in, row[23:8]};
		end
	end
	always @(negedge read_strobe_n) begin
		if (!ce_n) begin
			case (cmd)
				8'h70: dev_q = {wp_n, ready_busy_n, ready_busy_n, 4'h0, d0_f | d1_f};
				8'h71: dev_q = {wp_n, ready_busy_n, ready_busy_n, 2'b00, d1_f, d0_f, d0_f | d1_f};
				8'h90: dev_q = id_w[8 * rd_i +: 8];
				default: dev_q = src[7:0] + 8'(rd_i);
			endcase
			rd_i = rd_i + 3'd1;
		end
	end
	// Released bus must not keep showing the last byte
	always @(posedge read_strobe_n) #2 dev_q = ~dev_q;
endmodule

// *** sim/nfc_host_bench.sv ***
// Self-checking bench: APB software drives the NAND host against a device model
`timescale 1ns/1ps
`include "nfc_params.svh"
module nfc_host_bench;
	import nfc_pkg::*;
	localparam logic [7:0] MFR_CODE = 8'h5A; // Arbitrary value
	localparam logic [7:0] DEV_CODE = 8'hC3; // Arbitrary value
	localparam logic [7:0] ID3 = {4'h9, 2'($clog2(2) - 1), 2'($clog2(1))};
	localparam logic [7:0] ID4 = {2'b00, 2'($clog2(128 / 64)), 2'b01, 2'($clog2(2))};
	localparam logic [7:0] ID5 = {4'h7, 2'($clog2(2)), 2'b10};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fail_odd = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, cle, ale, ce_n, write_strobe_n, read_strobe_n, wp_n, bus_oe_n, ready_busy_n, err;
	logic [7:0] bus_out, dev_q;
	logic [10:0] blk_a, blk_b;
	wire [7:0] bus_in = !bus_oe_n ? bus_out : dev_q;
	int failures = 0, num_checks = 0, seed = 74;
	always #2.5 pclk = ~pclk;
	nfc_host uut (.*);
	nfc_dev #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE)) nand_dev (.*);
	function automatic logic [7:0] erase_st(input logic [10:0] blk);
		return {3'b111, 4'h0, blk[0]};
	endfunction
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) failures++;
	endtask
	task automatic idle();
		int n;
		n = 0;
		do apb(1'b0, `NFC_REG_STAT, 32'h0); while (rd[8] !== 1'b0 && ++n < 3000);
		if (n >= 3000) failures++;
	endtask
	task automatic op(input nfc_op_t o);
		apb(1'b1, `NFC_REG_CTRL, 32'h300 | 32'(o));
		idle();
	endtask
	task automatic st_rd(input nfc_op_t o);
		op(o);
		apb(1'b0, `NFC_REG_STAT, 32'h0);
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h020, 32'h0);
		cmp("hole slverr", 32'h1, 32'(err));
		cmp("hole data", 32'h0, rd);
		op(NFC_OP_ID);
		apb(1'b0, `NFC_REG_ID_LO, 32'h0);
		cmp("id low", {ID4, ID3, DEV_CODE, MFR_CODE}, rd);
		apb(1'b0, `NFC_REG_ID_HI, 32'h0);
		cmp("id high", 32'(ID5), 32'(rd[7:0]));
		fail_odd <= 1'b1;
		repeat (4) begin
			blk_a = 11'($random(seed));
			apb(1'b1, `NFC_REG_ADDR, {15'h0, blk_a, 6'h00});
			op(NFC_OP_ERASE);
			st_rd(NFC_OP_STATUS);
			cmp("erase status", 32'(erase_st(blk_a)), 32'(rd[7:0]));
		end
		for (int k = 0; k < 2; k++) begin
			blk_a = {10'($random(seed)), 1'(k)};
			blk_b = {10'($random(seed)), 1'(1 - k)};
			apb(1'b1, `NFC_REG_ADDR, {15'h0, blk_a, 6'h00});
			apb(1'b1, `NFC_REG_ADDR2, {15'h0, blk_b, 6'h00});
			op(NFC_OP_MERASE);
			st_rd(NFC_OP_DSTATUS);
			cmp("district status", 32'({3'b111, 2'b00, 1'b1, 1'b0, 1'b1}), 32'(rd[7:0]));
		end
		op(NFC_OP_RESET);
		st_rd(NFC_OP_STATUS);
		cmp("status after reset", 32'h0E0, 32'(rd[7:0]));
		fail_odd <= 1'b0;
		apb(1'b1, `NFC_REG_ADDR2, 32'h085);
		op(NFC_OP_COPY_START);
		op(NFC_OP_RDBYTE);
		apb(1'b0, `NFC_REG_RDATA, 32'h0);
		cmp("source byte", 32'h085, 32'(rd[7:0]));
		apb(1'b1, `NFC_REG_ADDR, 32'h0C0);
		op(NFC_OP_COPY_CACHE);
		op(NFC_OP_RDBYTE);
		apb(1'b0, `NFC_REG_RDATA, 32'h0);
		cmp("next source byte", 32'h086, 32'(rd[7:0]));
		apb(1'b0, `NFC_REG_STAT, 32'h0);
		cmp("chain flags", 32'h2, 32'(rd[10:9]));
		apb(1'b1, `NFC_REG_ADDR, 32'h101);
		op(NFC_OP_COPY_CACHE);
		apb(1'b0, `NFC_REG_STAT, 32'h0);
		cmp("block change", 32'h1, 32'(rd[9]));
		apb(1'b1, `NFC_REG_ADDR, 32'h0C2);
		op(NFC_OP_COPY_LAST);
		cmp("last destination", 32'h0C2, 32'(nand_dev.last_dst));
		cmp("pages programmed", 32'd3, 32'(nand_dev.prog_cnt));
		apb(1'b1, `NFC_REG_CTRL, 32'h300 | 32'(NFC_OP_ERASE));
		apb(1'b1, `NFC_REG_CTRL, 32'h300 | 32'(NFC_OP_ERASE));
		cmp("go while busy", 32'h1, 32'(err));
		idle();
		close_out();
	end
	// Whole sequence needs well under this span
	initial begin
		#400000;
		failures++;
		close_out();
	end
endmodule
bind nfc_host nfc_host_sva chk (.*);
